// file: logic/rac_bank.sv
// What this block does
// R01 - read/write bits read back last write
// R02 - read-only bits ignore writes
// R03 - write-only bits read undefined, here zero
// R04 - reserved bits always read zero
// R05 - software writes zero to reserved bits
// R06 - software never writes reserved field encodings
// R07 - read-only field shows only defined encodings
// R08 - never write reserved fuse bits
// R09 - resets load defaults, debug survives soft reset
// R10 - clear-alias one clears shared bit
// R11 - raise-alias one sets shared bit
// R12 - both aliases read same shared value
// R13 - simultaneous writes: clear wins
// R14 - zero written to alias changes nothing
`timescale 1ns/1ps
`include "rac_cfg.svh"
module rac_bank (
  // clock and resets
  input  wire logic              clk_sys_i,
  input  wire logic              reset_i,
  input  wire logic              soft_reset_i,
  // register access port
  input  wire logic              wr_en_i,
  input  wire logic              rd_en_i,
  input  wire rac_pkg::rac_idx_t addr_i,
  input  wire rac_pkg::rac_byte_t wdata_i,
  // second writer for the clear alias, same cycle as wr_en_i
  input  wire logic              clr_wr_en_i,
  input  wire rac_pkg::rac_byte_t clr_wdata_i,
  // hardware events that raise flags
  input  wire rac_pkg::rac_byte_t hw_set_i,
  // read data and block outputs
  output logic                   rdata_valid_o,
  output rac_pkg::rac_byte_t     rdata_o,
  output rac_pkg::rac_byte_t     ctrl_o,
  output rac_pkg::rac_byte_t     flags_o,
  output rac_pkg::rac_byte_t     cmd_pulse_o,
  output rac_pkg::rac_byte_t     dbg_o
);
  import rac_pkg::*;

  // register state
  rac_byte_t  ctrl_q;
  rac_byte_t  ctrl_d;
  rac_byte_t  flag_q;
  rac_byte_t  dbg_q;
  rac_byte_t  dbg_d;
  rac_byte_t  cmd_q;
  rac_byte_t  cmd_d;
  rac_byte_t  rdata_q;
  rac_byte_t  rdata_d;
  logic       rvalid_q;
  logic       rvalid_d;
  rac_state_t state_q;
  rac_state_t state_d;

  // reset qualifiers
  logic       power_reset;
  logic       any_reset;

  // address decode
  logic       hit_ctrl;
  logic       hit_status;
  logic       hit_cmd;
  logic       hit_set;
  logic       hit_clr;
  logic       hit_dbg;

  // write strobes
  logic       wr_ctrl;
  logic       wr_cmd;
  logic       wr_set;
  logic       wr_clr;
  logic       wr_dbg;

  // alias masks
  rac_byte_t  sw_set_bits;
  rac_byte_t  sw_clr_bits;
  rac_byte_t  extra_clr_bits;
  rac_byte_t  set_bits;
  rac_byte_t  clr_bits;
  wire [7:0]  flag_d;

  // control field and read path
  logic [1:0] mode_req;
  rac_byte_t  status_rd;
  rac_byte_t  rdata_sel;

  // soft reset spares the debug register only
  assign power_reset = reset_i;
  assign any_reset   = reset_i | soft_reset_i;

  assign hit_ctrl   = (addr_i == `RAC_IDX_CTRL);
  assign hit_status = (addr_i == `RAC_IDX_STATUS);
  assign hit_cmd    = (addr_i == `RAC_IDX_CMD);
  assign hit_set    = (addr_i == `RAC_IDX_FLAG_SET);
  assign hit_clr    = (addr_i == `RAC_IDX_FLAG_CLR);
  assign hit_dbg    = (addr_i == `RAC_IDX_DBG);

  assign wr_ctrl = wr_en_i & hit_ctrl;
  assign wr_cmd  = wr_en_i & hit_cmd;
  assign wr_set  = wr_en_i & hit_set;
  assign wr_clr  = wr_en_i & hit_clr;
  assign wr_dbg  = wr_en_i & hit_dbg;

  // only ones act; zeros leave the shared bit alone
  assign sw_set_bits    = wr_set ? wdata_i : `RAC_ZERO8; // R11 R14
  assign sw_clr_bits    = wr_clr ? wdata_i : `RAC_ZERO8; // R10 R14
  assign extra_clr_bits = clr_wr_en_i ? clr_wdata_i : `RAC_ZERO8; // R13
  assign set_bits       = sw_set_bits | hw_set_i; // R11
  assign clr_bits       = sw_clr_bits | extra_clr_bits; // R10

  // one cell per shared bit; clear wins, also over hardware set
  for (genvar i = 0; i < 8; i++) begin : g_flag
    assign flag_d[i] = clr_bits[i] ? 1'b0 // R10 R13
                                   : (flag_q[i] | set_bits[i]); // R11 R14
  end

  // reserved bits never stored
  assign ctrl_d = wr_ctrl ? (wdata_i & `RAC_CTRL_MASK) : ctrl_q; // R01 R04
  assign dbg_d  = wr_dbg ? wdata_i : dbg_q; // R01
  // command bits are write-only and self clearing
  assign cmd_d  = wr_cmd ? wdata_i : `RAC_ZERO8; // R03

  // reserved mode code 3 falls back to idle
  assign mode_req = ctrl_q[`RAC_MODE_LSB +: 2];
  always_comb begin
    case (mode_req)
      2'h1: begin
        state_d = RAC_ST_RUN;
      end
      2'h2: begin
        state_d = RAC_ST_HOLD;
      end
      default: begin
        state_d = RAC_ST_IDLE; // R07
      end
    endcase
  end

  // status shows the state code; upper bits reserved
  assign status_rd = {6'h00, state_q} & `RAC_STATUS_MASK; // R02 R04

  // cmd and unmapped indices select nothing and read zero
  assign rdata_sel = ({8{hit_ctrl}} & ctrl_q) // R01 R03 R04
                   | ({8{hit_status}} & status_rd) // R02
                   | ({8{hit_set | hit_clr}} & flag_q) // R12
                   | ({8{hit_dbg}} & dbg_q); // R01
  assign rdata_d  = rd_en_i ? rdata_sel : `RAC_ZERO8;
  assign rvalid_d = rd_en_i;

  // debug register survives a peripheral soft reset
  always_ff @(posedge clk_sys_i) begin
    if (power_reset) begin
      dbg_q <= `RAC_DBG_RST; // R09
    end else begin
      dbg_q <= dbg_d;
    end
  end

  // control register
  always_ff @(posedge clk_sys_i) begin
    if (any_reset) begin
      ctrl_q <= `RAC_CTRL_RST; // R09
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // shared flag value behind both aliases
  always_ff @(posedge clk_sys_i) begin
    if (any_reset) begin
      flag_q <= `RAC_FLAG_RST; // R09
    end else begin
      flag_q <= flag_d;
    end
  end

  // command pulse lasts one cycle
  always_ff @(posedge clk_sys_i) begin
    if (any_reset) begin
      cmd_q <= `RAC_ZERO8;
    end else begin
      cmd_q <= cmd_d;
    end
  end

  // state lags control by one cycle
  always_ff @(posedge clk_sys_i) begin
    if (any_reset) begin
      state_q <= RAC_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // read data is zero whenever it is not valid
  always_ff @(posedge clk_sys_i) begin
    if (any_reset) begin
      rdata_q <= `RAC_ZERO8;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // read valid pulse
  always_ff @(posedge clk_sys_i) begin
    if (any_reset) begin
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= rvalid_d;
    end
  end

  // outputs straight from the flops
  assign rdata_valid_o = rvalid_q;
  assign rdata_o       = rdata_q;
  assign ctrl_o        = ctrl_q;
  assign flags_o       = flag_q;
  assign cmd_pulse_o   = cmd_q;
  assign dbg_o         = dbg_q;
endmodule

// file: pkg/rac_cfg.svh
`ifndef RAC_CFG_SVH
`define RAC_CFG_SVH
// register index within the bank
`define RAC_IDX_CTRL      3'h0
`define RAC_IDX_STATUS    3'h1
`define RAC_IDX_CMD       3'h2
`define RAC_IDX_FLAG_SET  3'h3
`define RAC_IDX_FLAG_CLR  3'h4
`define RAC_IDX_DBG       3'h5
// ctrl: bits 5:0 used, 7:6 reserved
`define RAC_CTRL_MASK     8'h3F
`define RAC_CTRL_RST      8'h00
// ctrl mode field position, 2 bits
`define RAC_MODE_LSB      4
// status: mask keeps bits 3:0, state code uses bits 1:0 only
`define RAC_STATUS_MASK   8'h0F
`define RAC_FLAG_RST      8'h00
`define RAC_DBG_RST       8'h00
`define RAC_ZERO8         8'h00
`endif

// file: pkg/rac_pkg.sv
package rac_pkg;
  typedef logic [7:0] rac_byte_t;
  typedef logic [2:0] rac_idx_t;
  // defined encodings of the read-only state field
  typedef enum logic [1:0] {
    RAC_ST_IDLE = 2'h0,
    RAC_ST_RUN  = 2'h1,
    RAC_ST_HOLD = 2'h2
  } rac_state_t;
endpackage

// file: verification/rac_bank_asserts.sv
`timescale 1ns/1ps
module rac_bank_asserts (
  input wire logic       clk_sys_i, reset_i, soft_reset_i, wr_en_i,
  input wire logic       rd_en_i, clr_wr_en_i, rdata_valid_o,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i, clr_wdata_i, hw_set_i, rdata_o,
  input wire logic [7:0] ctrl_o, flags_o, cmd_pulse_o, dbg_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i || soft_reset_i);
  wire w_set = wr_en_i && addr_i == 3'h3;
  property p_rsv; ctrl_o[7:6] == 2'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("ctrl rsv");
  property p_rw; wr_en_i && addr_i == 3'h0 |=>
    ctrl_o == ($past(wdata_i) & 8'h3F); endproperty
  a_rw: assert property (p_rw) else $error("ctrl wr");
  property p_set; w_set && !clr_wr_en_i |=>
    &(flags_o | ~$past(wdata_i)); endproperty
  a_set: assert property (p_set) else $error("set");
  property p_clr; wr_en_i && addr_i == 3'h4 |=>
    !(flags_o & $past(wdata_i)); endproperty
  a_clr: assert property (p_clr) else $error("clr");
  property p_win; w_set && clr_wr_en_i |=>
    !(flags_o & $past(clr_wdata_i)); endproperty
  a_win: assert property (p_win) else $error("clr win");
  property p_keep; !wr_en_i && !clr_wr_en_i && !hw_set_i &&
    !soft_reset_i |=> $stable(flags_o); endproperty
  a_keep: assert property (p_keep) else $error("keep");
  property p_rd; rd_en_i && (addr_i == 3'h3 || addr_i == 3'h4) |=>
    rdata_o == $past(flags_o); endproperty
  a_rd: assert property (p_rd) else $error("alias rd");
  property p_st; rd_en_i && addr_i == 3'h1 |=>
    rdata_o[1:0] != 2'h3 && !rdata_o[7:4]; endproperty
  a_st: assert property (p_st) else $error("status");
endmodule
bind rac_bank rac_bank_asserts u_chk (.*);

// file: verification/rac_bank_tb_top.sv
`timescale 1ns/1ps
module rac_bank_tb_top;
  import rac_pkg::*;
  logic      clk_sys_i = 0, reset_i = 1, soft_reset_i = 0, rdata_valid_o;
  logic      wr_en_i = 0, rd_en_i = 0, clr_wr_en_i = 0;
  rac_idx_t  addr_i = 3'h0;
  rac_byte_t wdata_i = 8'h00, clr_wdata_i = 8'h00, hw_set_i = 8'h00;
  rac_byte_t rdata_o, ctrl_o, flags_o, cmd_pulse_o, dbg_o;
  int        fail_count = 0, samples_checked = 0;
  rac_bank dut (.*);
  always #12.5 clk_sys_i = ~clk_sys_i;
  task automatic chk(rac_byte_t g, rac_byte_t e);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // c nonzero adds a same-cycle clear-alias write
  task automatic wr(rac_idx_t a, rac_byte_t d, rac_byte_t c);
    @(negedge clk_sys_i);
    {wr_en_i, addr_i, wdata_i, clr_wr_en_i, clr_wdata_i} = {1'b1, a, d, |c, c};
    @(negedge clk_sys_i);
    {wr_en_i, clr_wr_en_i} = 2'b00;
  endtask
  task automatic rd(rac_idx_t a, rac_byte_t m, rac_byte_t e);
    @(negedge clk_sys_i);
    {rd_en_i, addr_i} = {1'b1, a};
    @(negedge clk_sys_i);
    rd_en_i = 1'b0;
    chk({7'h0, rdata_valid_o}, 8'h01);
    chk(rdata_o & m, e);
  endtask
  task automatic t_access;
    chk(ctrl_o | flags_o | dbg_o, 8'h00);
    wr(3'h0, 8'hEF, 8'h00);
    rd(3'h0, 8'hFF, 8'h2F);
    rd(3'h1, 8'hFF, 8'h02);
    wr(3'h0, 8'h10, 8'h00);
    wr(3'h1, 8'hFF, 8'h00);
    rd(3'h1, 8'hFF, 8'h01);
    wr(3'h2, 8'hA5, 8'h00);
    chk(cmd_pulse_o, 8'hA5);
    rd(3'h2, 8'hFF, 8'h00);
    chk(cmd_pulse_o, 8'h00);
    rd(3'h7, 8'hFF, 8'h00);
  endtask
  task automatic t_alias;
    wr(3'h3, 8'h0F, 8'h00);
    rd(3'h4, 8'hFF, 8'h0F);
    wr(3'h4, 8'h03, 8'h00);
    rd(3'h3, 8'hFF, 8'h0C);
    wr(3'h3, 8'h00, 8'h00);
    chk(flags_o, 8'h0C);
    wr(3'h3, 8'hF0, 8'h30);
    chk(flags_o, 8'hCC);
    @(negedge clk_sys_i) hw_set_i = 8'h01;
    @(negedge clk_sys_i) hw_set_i = 8'h00;
    chk(flags_o, 8'hCD);
  endtask
  task automatic t_reset;
    wr(3'h5, 8'h5A, 8'h00);
    @(negedge clk_sys_i) soft_reset_i = 1'b1;
    @(negedge clk_sys_i) soft_reset_i = 1'b0;
    chk(dbg_o, 8'h5A);
    chk(flags_o | ctrl_o, 8'h00);
    @(negedge clk_sys_i) reset_i = 1'b1;
    @(negedge clk_sys_i) reset_i = 1'b0;
    chk(dbg_o, 8'h00);
  endtask
  task automatic stop_test;
    if (fail_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk_sys_i);
    reset_i = 1'b0;
    t_access;
    t_alias;
    t_reset;
    stop_test;
  end
  initial begin
    #20us;
    fail_count++;
    stop_test;
  end
endmodule
